/* File: include/hcp_pkg.sv */
// Package with offsets, field layouts and fixed values of the capability parameter registers.
package hcp_pkg;

  // ==========================================================================
  // Register map
  localparam logic [9:0] HCP_STRUCT_OFFSET = 10'h004;
  localparam logic [9:0] HCP_CAPAB_OFFSET  = 10'h008;
  localparam int         HCP_ADDR_WIDTH    = 10;
  localparam int         HCP_DATA_WIDTH    = 32;

  // ==========================================================================
  // Field values
  localparam logic [3:0] HCP_DEBUG_PORT_NUMBER   = 4'h0;
  localparam logic       HCP_PORT_INDICATOR      = 1'b0;
  localparam logic [3:0] HCP_COMPANION_COUNT     = 4'h0;
  localparam logic [3:0] HCP_PORTS_PER_COMPANION = 4'h0;
  localparam logic       HCP_PORT_ROUTING_METHOD = 1'b0;
  localparam logic       HCP_PORT_POWER_SWITCH   = 1'b1;
  localparam logic [3:0] HCP_PORT_COUNT          = 4'h1;
  localparam logic [7:0] HCP_EXT_CAP_POINTER     = 8'h00;
  localparam logic [3:0] HCP_ISO_THRESHOLD       = 4'h8;
  localparam logic       HCP_ASYNC_PARK          = 1'b1;
  localparam logic       HCP_PROG_FRAME_LIST     = 1'b1;
  localparam logic       HCP_WIDE_ADDRESSING     = 1'b0;
  localparam logic [31:0] HCP_READ_RESET         = 32'h0000_0000;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic [7:0] reserved_hi;
    logic [3:0] debug_port_number;
    logic [2:0] reserved_mid;
    logic       port_indicator;
    logic [3:0] companion_count;
    logic [3:0] ports_per_companion;
    logic       port_routing_method;
    logic [1:0] reserved_lo;
    logic       port_power_switching;
    logic [3:0] port_count;
  } hcp_struct_type;

  typedef struct packed {
    logic [15:0] reserved_hi;
    logic [7:0]  extended_capability_pointer;
    logic [3:0]  iso_schedule_threshold;
    logic        reserved_lo;
    logic        async_park_support;
    logic        programmable_frame_list;
    logic        wide_addressing_support;
  } hcp_capab_type;

  typedef struct packed {
    logic                      read;
    logic [HCP_ADDR_WIDTH-1:0] addr;
  } hcp_req_type;

endpackage

/* File: hdl/hcp_rom.sv */
// Small constant table returning the selected capability word through a register.
`timescale 1ns/100ps
module hcp_rom
  import hcp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_sel_struct,
  input  wire logic        i_sel_capab,
  output logic      [31:0] o_data
);

  // ==========================================================================
  // Fixed contents
  hcp_struct_type struct_word;
  hcp_capab_type  capab_word;
  logic [31:0]    data_r;
  logic [31:0]    data_nxt;

  always_comb begin
    struct_word                      = '0;
    struct_word.debug_port_number    = HCP_DEBUG_PORT_NUMBER;
    struct_word.port_indicator       = HCP_PORT_INDICATOR;
    struct_word.companion_count      = HCP_COMPANION_COUNT;
    struct_word.ports_per_companion  = HCP_PORTS_PER_COMPANION;
    struct_word.port_routing_method  = HCP_PORT_ROUTING_METHOD;
    struct_word.port_power_switching = HCP_PORT_POWER_SWITCH;
    struct_word.port_count           = HCP_PORT_COUNT;
    capab_word                             = '0;
    capab_word.extended_capability_pointer = HCP_EXT_CAP_POINTER;
    capab_word.iso_schedule_threshold      = HCP_ISO_THRESHOLD;
    capab_word.async_park_support          = HCP_ASYNC_PARK;
    capab_word.programmable_frame_list     = HCP_PROG_FRAME_LIST;
    capab_word.wide_addressing_support     = HCP_WIDE_ADDRESSING;
  end

  always_comb begin
    data_nxt = HCP_READ_RESET;
    if (i_sel_struct) begin
      data_nxt = struct_word;
    end else if (i_sel_capab) begin
      data_nxt = capab_word;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      data_r <= HCP_READ_RESET;
    end else begin
      data_r <= data_nxt;
    end
  end

  assign o_data = data_r;

endmodule // hcp_rom

/* File: hdl/hcp_regs.sv */
// Read-only capability parameter registers behind the processor register port.
// Function
// - Debug port number field reads zero.
// - Port indicator bit reads zero.
// - Companion controller count reads zero.
// - Ports per companion field reads zero.
// - Port routing method bit reads zero.
// - Port power switching bit reads one.
// - Port count field reads one.
// - Extended capability pointer reads zero.
// - Isochronous threshold field reads binary 1000.
// - Async park support bit reads one.
// - Programmable frame list bit reads one.
// - Wide addressing bit reads zero.
// - Reserved bits read zero; software writes zero.
// - Read-only words at 0004h, 0008h; writes ignored.
`timescale 1ns/100ps
module hcp_regs
  import hcp_pkg::*;
(
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_b,
  input  wire logic                      i_read,
  input  wire logic                      i_write,
  input  wire logic [HCP_ADDR_WIDTH-1:0] i_addr,
  input  wire logic [31:0]               i_wdata,
  output logic      [31:0]               o_rdata,
  output logic                           o_rvalid
);

  // ==========================================================================
  // Request decode
  // Writes and i_wdata are deliberately ignored: nothing here can be changed.
  hcp_req_type req;
  logic        sel_struct;
  logic        sel_capab;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rom_data;

  always_comb begin
    req.read   = i_read;
    req.addr   = i_addr;
    sel_struct = req.read && (req.addr == HCP_STRUCT_OFFSET);
    sel_capab  = req.read && (req.addr == HCP_CAPAB_OFFSET);
    rvalid_nxt = req.read;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  // Unmapped reads return zero so a sweep of the map sees no stale word.
  hcp_rom hcp_rom_inst (
    .i_clock      (i_clock),
    .i_rst_b      (i_rst_b),
    .i_sel_struct (sel_struct),
    .i_sel_capab  (sel_capab),
    .o_data       (rom_data)
  );

  assign o_rdata  = rom_data;
  assign o_rvalid = rvalid_r;

  // ==========================================================================
  // Assertions
  // Registered copies of the decode, cleared by reset, mark the cycle in which a mapped word
  // is answered; a read presented while reset is held must not make the checks expect a word.
  logic struct_seen_r;
  logic struct_seen_nxt;
  logic capab_seen_r;
  logic capab_seen_nxt;

  always_comb begin
    struct_seen_nxt = sel_struct;
    capab_seen_nxt  = sel_capab;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      struct_seen_r <= 1'b0;
      capab_seen_r  <= 1'b0;
    end else begin
      struct_seen_r <= struct_seen_nxt;
      capab_seen_r  <= capab_seen_nxt;
    end
  end

  a_struct_value: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_read && i_addr == HCP_STRUCT_OFFSET |=> o_rvalid && o_rdata == 32'h0000_0011
  ) else $error("structural word wrong");

  a_capab_value: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_read && i_addr == HCP_CAPAB_OFFSET |=> o_rvalid && o_rdata == 32'h0000_0086
  ) else $error("capability word wrong");

  a_debug_port: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[23:20] == 4'h0
  ) else $error("debug port nonzero");

  a_port_indic: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> !o_rdata[16]
  ) else $error("indicator set");

  a_companion_cnt: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[15:12] == 4'h0
  ) else $error("companions nonzero");

  a_per_companion: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[11:8] == 4'h0
  ) else $error("per companion nonzero");

  a_port_routing: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> !o_rdata[7]
  ) else $error("routing bit set");

  a_power_switch: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[4]
  ) else $error("power switching clear");

  a_port_count: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[3:0] == 4'h1
  ) else $error("port count not one");

  a_ext_pointer: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> o_rdata[15:8] == 8'h00
  ) else $error("ext pointer nonzero");

  a_iso_threshold: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> o_rdata[7:4] == 4'h8
  ) else $error("iso threshold wrong");

  a_async_park: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> o_rdata[2]
  ) else $error("park bit clear");

  a_frame_list: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> o_rdata[1]
  ) else $error("frame list bit clear");

  a_wide_addr: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> !o_rdata[0]
  ) else $error("wide addressing set");

  a_reserved_zero: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_rvalid |-> o_rdata[31:24] == 8'h00 && o_rdata[6:5] == 2'b00
  ) else $error("reserved set");

  a_struct_reserved: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    struct_seen_r |-> o_rdata[31:24] == 8'h00 && o_rdata[19:17] == 3'b000 && o_rdata[6:5] == 2'b00
  ) else $error("structural reserved set");

  a_capab_reserved: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    capab_seen_r |-> o_rdata[31:16] == 16'h0000 && !o_rdata[3]
  ) else $error("capability reserved set");

  a_write_ignored: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_write && !i_read |=> !o_rvalid && o_rdata == 32'h0000_0000
  ) else $error("write changed data");

  a_write_with_read: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_read && i_write && i_addr == HCP_CAPAB_OFFSET |=> o_rvalid && o_rdata == 32'h0000_0086
  ) else $error("write disturbed read");

  a_read_stable: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    sel_struct ##1 sel_struct |=> o_rdata == $past(o_rdata)
  ) else $error("read unstable");

  a_capab_stable: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    sel_capab ##1 sel_capab |=> o_rdata == $past(o_rdata)
  ) else $error("capability read unstable");

  a_unmapped_zero: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_read && !sel_struct && !sel_capab |=> o_rvalid && o_rdata == 32'h0000_0000
  ) else $error("unmapped not zero");

  a_answer_pulse: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_read |=> o_rvalid
  ) else $error("read not answered");

  a_answer_drop: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !i_read |=> !o_rvalid
  ) else $error("answer without read");

  // Reset is deliberately not a disable here: this one watches the outputs it leaves behind.
  a_reset_quiet: assert property (
    @(posedge i_clock)
    !i_rst_b |=> !o_rvalid && o_rdata == 32'h0000_0000
  ) else $error("outputs not cleared by reset");

  c_read_struct: cover property (@(posedge i_clock) disable iff (!i_rst_b) sel_struct);
  c_read_capab: cover property (@(posedge i_clock) disable iff (!i_rst_b) sel_capab);
  c_back_to_back: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    sel_struct ##1 sel_capab);
  c_write_try: cover property (@(posedge i_clock) disable iff (!i_rst_b) i_write);
  c_write_with_read: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    i_read && i_write);

endmodule // hcp_regs

/* File: tb/testbench.sv */
// Self-checking testbench for the read-only capability parameter registers.
`timescale 1ns/100ps
module testbench
  import hcp_pkg::*;
;
  // ==========================================================================
  // Signals and expected words
  localparam logic [31:0] EXP_STRUCT = 32'h0000_0011;
  localparam logic [31:0] EXP_CAPAB  = 32'h0000_0086;
  logic                      i_clock;
  logic                      i_rst_b;
  logic                      i_read;
  logic                      i_write;
  logic [HCP_ADDR_WIDTH-1:0] i_addr;
  logic [31:0]               i_wdata;
  logic [31:0]               o_rdata;
  logic                      o_rvalid;
  int                        num_errors;
  int                        n_tests;
  logic [31:0]               word;
  hcp_struct_type            sp;
  hcp_capab_type             cp;

  initial i_clock = 1'b0;
  always #10 i_clock = ~i_clock;

  hcp_regs hcp_regs_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_read(i_read),
    .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid));

  // ==========================================================================
  // Shared tasks
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The answer stands one cycle only, so it is sampled in that cycle and then seen to drop.
  task automatic read_reg(input logic [9:0] addr, output logic [31:0] data);
    @(negedge i_clock);
    i_read = 1'b1;
    i_addr = addr;
    @(negedge i_clock);
    i_read = 1'b0;
    check_word("read valid", 32'h1, {31'h0, o_rvalid});
    data = o_rdata;
    @(negedge i_clock);
    check_word("idle valid", 32'h0, {31'h0, o_rvalid});
    check_word("idle data", 32'h0, o_rdata);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_fields();
    read_reg(HCP_STRUCT_OFFSET, word);
    sp = hcp_struct_type'(word);
    check_word("debug port", 32'h0, {28'h0, sp.debug_port_number});
    check_word("indicator", 32'h0, {31'h0, sp.port_indicator});
    check_word("companions", 32'h0, {28'h0, sp.companion_count});
    check_word("per companion", 32'h0, {28'h0, sp.ports_per_companion});
    check_word("routing", 32'h0, {31'h0, sp.port_routing_method});
    check_word("power switch", 32'h1, {31'h0, sp.port_power_switching});
    check_word("port count", 32'h1, {28'h0, sp.port_count});
    check_word("struct word", EXP_STRUCT, word);
    read_reg(HCP_CAPAB_OFFSET, word);
    cp = hcp_capab_type'(word);
    check_word("ext pointer", 32'h0, {24'h0, cp.extended_capability_pointer});
    check_word("iso threshold", 32'h8, {28'h0, cp.iso_schedule_threshold});
    check_word("park", 32'h1, {31'h0, cp.async_park_support});
    check_word("frame list", 32'h1, {31'h0, cp.programmable_frame_list});
    check_word("wide addr", 32'h0, {31'h0, cp.wide_addressing_support});
    check_word("capab word", EXP_CAPAB, word);
    $display("test_fields done");
  endtask

  task automatic test_write_ignored();
    @(negedge i_clock);
    i_write = 1'b1;
    i_wdata = 32'h00f1_ff9f;
    i_addr = HCP_STRUCT_OFFSET;
    @(negedge i_clock);
    i_wdata = 32'h0000_fff7;
    i_addr = HCP_CAPAB_OFFSET;
    @(negedge i_clock);
    i_write = 1'b0;
    check_word("write answer", 32'h0, {31'h0, o_rvalid});
    read_reg(HCP_STRUCT_OFFSET, word);
    check_word("struct after write", EXP_STRUCT, word);
    // A write held high across the read must lose to it; its data keeps every reserved bit low.
    i_write = 1'b1;
    i_wdata = 32'h0000_ff97;
    read_reg(HCP_CAPAB_OFFSET, word);
    i_write = 1'b0;
    check_word("capab after write", EXP_CAPAB, word);
    $display("test_write_ignored done");
  endtask

  // Two reads of each word back to back, as a sixteen-bit processor would issue them.
  task automatic test_back_to_back();
    for (int k = 0; k < 5; k++) begin
      @(negedge i_clock);
      if (k > 0) begin
        check_word("burst valid", 32'h1, {31'h0, o_rvalid});
        check_word("burst data", (k > 2) ? EXP_CAPAB : EXP_STRUCT, o_rdata);
      end
      i_read = (k < 4);
      i_addr = (k >= 2) ? HCP_CAPAB_OFFSET : HCP_STRUCT_OFFSET;
    end
    $display("test_back_to_back done");
  endtask

  task automatic test_unmapped();
    logic [9:0] bad [4] = '{10'h000, 10'h005, 10'h00c, 10'h3ff};
    for (int k = 0; k < 4; k++) begin
      read_reg(bad[k], word);
      check_word("unmapped data", 32'h0, word);
    end
    $display("test_unmapped done");
  endtask

  task automatic test_reset_quiet();
    @(negedge i_clock);
    i_rst_b = 1'b0;
    i_read = 1'b1;
    i_addr = HCP_STRUCT_OFFSET;
    @(negedge i_clock);
    check_word("reset valid", 32'h0, {31'h0, o_rvalid});
    check_word("reset data", 32'h0, o_rdata);
    i_read = 1'b0;
    i_rst_b = 1'b1;
    read_reg(HCP_STRUCT_OFFSET, word);
    check_word("struct after reset", EXP_STRUCT, word);
    $display("test_reset_quiet done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    num_errors = 0;
    n_tests = 0;
    i_rst_b = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_addr = 10'h000;
    i_wdata = 32'h0;
    repeat (8) @(negedge i_clock);
    i_rst_b = 1'b1;
    test_fields();
    test_write_ignored();
    test_back_to_back();
    test_unmapped();
    test_reset_quiet();
    complete_run();
  end

  initial begin
    repeat (2000) @(posedge i_clock);
    num_errors++;
    $display("Watchdog expired");
    complete_run();
  end
endmodule // testbench
